// *** design/cpsm_ctrl.sv ***
// power-saving mode controller: slow-run throttle, idle, sleep and wake
// assumes the core sequencer gives same-clock pulses; reset pins are async
`default_nettype none

module cpsm_ctrl #(
  parameter int OST_CYCLES = cpsm_pkg::OST_CYCLES,
  parameter int REG_CYCLES = cpsm_pkg::REG_STAB_CYCLES,
  parameter bit REG_PRESENT = 1'h1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sw_write,
  input wire cpsm_pkg::cpsm_sw_t sw_data,
  input wire logic [cpsm_pkg::RATIO_W-1:0] cycle_ratio,
  input wire logic recover_on_irq,
  input wire logic idle_select,
  input wire logic global_irq_enable,
  input wire logic regulator_lowpower_sleep,
  input wire logic crystal_osc_mode,
  input wire logic adc_rc_clock,
  input wire logic sleep_exec,
  input wire logic irq_entry_req,
  input wire logic irq_return,
  input wire logic prefetch_clears_gie,
  input wire logic multicycle_busy,
  input wire logic irq_pending_enabled,
  input wire logic irq_any,
  input wire logic wdt_wake,
  input wire cpsm_pkg::cpsm_osc_t osc_request,
  input wire cpsm_pkg::cpsm_osc_t osc_force_on,
  input wire logic [cpsm_pkg::IO_PORTS-1:0] port_periph_active,
  input wire logic external_reset_pin,
  input wire logic brownout_evt,
  input wire logic poweron_evt,
  output logic cpu_cycle_enable,
  output logic periph_cycle_enable,
  output logic cpu_clk_run,
  output logic sys_clk_run,
  output logic slow_run_enable,
  output logic slow_on_return,
  output logic powerdown_flag_n,
  output logic timeout_flag_n,
  output logic wdt_clear,
  output logic adc_abort,
  output logic adc_powered,
  output cpsm_pkg::cpsm_osc_t osc_run,
  output logic [cpsm_pkg::IO_PORTS-1:0] io_hold,
  output logic regulator_lowpower,
  output logic full_reset_req,
  output logic vector_fetch,
  output logic [cpsm_pkg::ADDR_W-1:0] vector_addr,
  output logic isr_skipped,
  output logic prefetch_next,
  output logic exec_prefetched,
  output logic in_idle,
  output logic in_sleep
);

  // ==========================================================
  // state and events
  // ==========================================================
  cpsm_pkg::cpsm_state_t q;       // registered state
  cpsm_pkg::cpsm_state_t next_q;  // next state
  logic reset_evt;                // a synchronised reset source is high
  logic sleep_go;                 // sleep instruction taken in run
  logic sleep_nop;                // sleep turned into a no-op
  logic sleep_full;               // true sleep entry
  logic entry_go;                 // interrupt entry performed
  logic wake_go;                  // wake event while asleep

  assign reset_evt = |q.sync2;
  assign sleep_go = (q.mode == cpsm_pkg::CPSM_RUN) && sleep_exec && !reset_evt;
  assign sleep_nop = !idle_select && !global_irq_enable && irq_pending_enabled;
  assign sleep_full = sleep_go && !idle_select && !sleep_nop;
  assign entry_go = (q.mode == cpsm_pkg::CPSM_RUN) && !sleep_exec && q.irq_pend
    && !multicycle_busy && !reset_evt;
  assign wake_go = (q.mode == cpsm_pkg::CPSM_SLEEP) && !reset_evt
    && (irq_pending_enabled || wdt_wake);

  // ==========================================================
  // next-state logic
  // ==========================================================
  always_comb begin
    next_q = q;
    // one-cycle pulses fall back to zero
    next_q.wdt_clear = 1'h0;
    next_q.adc_abort = 1'h0;
    next_q.vector_fetch = 1'h0;
    next_q.isr_skipped = 1'h0;
    next_q.prefetch_next = 1'h0;
    next_q.exec_prefetched = 1'h0;
    next_q.full_reset_req = 1'h0;
    next_q.vector_addr = cpsm_pkg::IRQ_VECTOR;
    // two-stage synchroniser for the asynchronous reset sources
    next_q.sync1[cpsm_pkg::PIN_EXT_RESET] = external_reset_pin;
    next_q.sync1[cpsm_pkg::PIN_BROWNOUT] = brownout_evt;
    next_q.sync1[cpsm_pkg::PIN_POWERON] = poweron_evt;
    next_q.sync2 = q.sync1;

    // software write; hardware updates below override it
    if (sw_write) begin
      next_q.slow_run_enable = sw_data.slow_run_enable;
      next_q.slow_on_return = sw_data.slow_on_return;
    end
    // return from service restores the throttle
    if (irq_return) begin
      next_q.slow_run_enable = q.slow_on_return;
    end

    unique case (q.mode)
      cpsm_pkg::CPSM_RUN: begin
        if (sleep_exec) begin
          // next instruction is fetched while sleep executes
          next_q.prefetch_next = 1'h1;
          if (idle_select) begin
            next_q.mode = cpsm_pkg::CPSM_IDLE;
          end else if (sleep_nop) begin
            // pending enabled interrupt with gie off: stays in run, flags untouched, only prefetch_next pulses
            next_q.mode = cpsm_pkg::CPSM_RUN;
          end else begin
            next_q.mode = cpsm_pkg::CPSM_SLEEP;
            next_q.wdt_clear = 1'h1;
            next_q.powerdown_flag_n = 1'h0;
            next_q.timeout_flag_n = 1'h1;
            next_q.adc_abort = !adc_rc_clock;
            next_q.io_latch = ~port_periph_active;
          end
        end else if (q.irq_pend && !multicycle_busy) begin
          // entry waits while a multicycle instruction completes
          next_q.irq_pend = 1'h0;
          next_q.slow_on_return = q.slow_run_enable;
          if (recover_on_irq) begin
            next_q.slow_run_enable = 1'h0;
          end
          if (prefetch_clears_gie) begin
            next_q.isr_skipped = 1'h1;
          end else begin
            next_q.vector_fetch = 1'h1;
          end
        end
      end
      cpsm_pkg::CPSM_IDLE: begin
        // any interrupt ends idle, gie or not; watchdog wakes too
        if (irq_any || wdt_wake) begin
          next_q.mode = cpsm_pkg::CPSM_RUN;
        end
      end
      cpsm_pkg::CPSM_SLEEP: begin
        // enabled interrupt or watchdog wakes at once
        if (irq_pending_enabled || wdt_wake) begin
          next_q.wdt_clear = 1'h1;
          next_q.wake_irq = irq_pending_enabled;
          next_q.timer = '0;
          if (crystal_osc_mode) begin
            next_q.mode = cpsm_pkg::CPSM_WAKE_OST;
          end else if (regulator_lowpower_sleep && REG_PRESENT) begin
            next_q.mode = cpsm_pkg::CPSM_WAKE_REG;
          end else begin
            next_q.mode = cpsm_pkg::CPSM_RESUME;
          end
        end
      end
      cpsm_pkg::CPSM_WAKE_OST: begin
        // oscillator start-up count
        if (q.timer == cpsm_pkg::TMR_W'(OST_CYCLES - 1)) begin
          next_q.timer = '0;
          if (regulator_lowpower_sleep && REG_PRESENT) begin
            next_q.mode = cpsm_pkg::CPSM_WAKE_REG;
          end else begin
            next_q.mode = cpsm_pkg::CPSM_RESUME;
          end
        end else begin
          next_q.timer = q.timer + 1'h1;
        end
      end
      cpsm_pkg::CPSM_WAKE_REG: begin
        // regulator returns from its low-power state
        if (q.timer == cpsm_pkg::TMR_W'(REG_CYCLES - 1)) begin
          next_q.timer = '0;
          next_q.mode = cpsm_pkg::CPSM_RESUME;
        end else begin
          next_q.timer = q.timer + 1'h1;
        end
      end
      cpsm_pkg::CPSM_RESUME: begin
        // prefetched instruction runs, then the isr if an interrupt woke it and gie is set
        next_q.exec_prefetched = 1'h1;
        next_q.mode = cpsm_pkg::CPSM_RUN;
        if (q.wake_irq && global_irq_enable) begin
          next_q.irq_pend = 1'h1;
        end
      end
      default: begin
        next_q.mode = cpsm_pkg::CPSM_RUN;
      end
    endcase

    // a new entry request wins over the clear of the pending bit
    if (irq_entry_req) begin
      next_q.irq_pend = 1'h1;
    end

    // reset pins, brown-out and power-on restart the device
    if (reset_evt) begin
      next_q.mode = cpsm_pkg::CPSM_RUN;
      next_q.full_reset_req = 1'h1;
      next_q.irq_pend = 1'h0;
      next_q.slow_run_enable = 1'h0;
      next_q.slow_on_return = 1'h0;
      next_q.timer = '0;
    end

    // mode-derived outputs, registered with the mode
    next_q.in_sleep = (next_q.mode == cpsm_pkg::CPSM_SLEEP);
    next_q.in_idle = (next_q.mode == cpsm_pkg::CPSM_IDLE);
    next_q.cpu_clk_run = (next_q.mode == cpsm_pkg::CPSM_RUN)
      || (next_q.mode == cpsm_pkg::CPSM_RESUME);
    next_q.sys_clk_run = !next_q.in_sleep
      && (next_q.mode != cpsm_pkg::CPSM_WAKE_OST);
    // peripherals ignore the throttle and run in idle
    next_q.periph_cycle_enable = next_q.sys_clk_run;
    if (next_q.in_sleep) begin
      next_q.osc_run = cpsm_pkg::cpsm_osc_t'(osc_request | osc_force_on);
      next_q.io_hold = next_q.io_latch & ~port_periph_active;
    end else begin
      next_q.osc_run = '1;
      next_q.io_hold = '0;
    end
    next_q.adc_powered = !(next_q.in_sleep && !adc_rc_clock);
    next_q.regulator_lowpower = next_q.in_sleep && regulator_lowpower_sleep
      && REG_PRESENT;
  end

  // ==========================================================
  // state register
  // ==========================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.powerdown_flag_n <= cpsm_pkg::FLAG_RST;
      q.timeout_flag_n <= cpsm_pkg::FLAG_RST;
      q.cpu_clk_run <= cpsm_pkg::RUN_RST;
      q.sys_clk_run <= cpsm_pkg::RUN_RST;
      q.periph_cycle_enable <= cpsm_pkg::RUN_RST;
      q.adc_powered <= cpsm_pkg::RUN_RST;
      q.osc_run <= '1;
      q.vector_addr <= cpsm_pkg::IRQ_VECTOR;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // cpu cycle throttle
  // ==========================================================
  cpsm_doze_div u_doze (
    .clk(clk),
    .rst(rst),
    .enable(q.slow_run_enable),
    .ratio(cycle_ratio),
    .run(q.cpu_clk_run),
    .cpu_cycle(cpu_cycle_enable)
  );

  // outputs straight from the state register
  assign periph_cycle_enable = q.periph_cycle_enable;
  assign cpu_clk_run = q.cpu_clk_run;
  assign sys_clk_run = q.sys_clk_run;
  assign slow_run_enable = q.slow_run_enable;
  assign slow_on_return = q.slow_on_return;
  assign powerdown_flag_n = q.powerdown_flag_n;
  assign timeout_flag_n = q.timeout_flag_n;
  assign wdt_clear = q.wdt_clear;
  assign adc_abort = q.adc_abort;
  assign adc_powered = q.adc_powered;
  assign osc_run = q.osc_run;
  assign io_hold = q.io_hold;
  assign regulator_lowpower = q.regulator_lowpower;
  assign full_reset_req = q.full_reset_req;
  assign vector_fetch = q.vector_fetch;
  assign vector_addr = q.vector_addr;
  assign isr_skipped = q.isr_skipped;
  assign prefetch_next = q.prefetch_next;
  assign exec_prefetched = q.exec_prefetched;
  assign in_idle = q.in_idle;
  assign in_sleep = q.in_sleep;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_crystal_wake;
    wake_go && crystal_osc_mode;
  endsequence

  sequence s_held_off;
    !exec_prefetched && !cpu_clk_run;
  endsequence

  a_sleep_flags: assert property (sleep_full |=> !powerdown_flag_n && timeout_flag_n)
    else $error("sleep entry flags wrong");
  a_sleep_wdt: assert property (sleep_full |=> wdt_clear && in_sleep)
    else $error("sleep entry did not clear watchdog");
  a_sleep_nop: assert property (sleep_go && sleep_nop
    |=> !wdt_clear && !in_sleep && $stable(powerdown_flag_n))
    else $error("sleep not turned into no-op");
  a_idle_entry: assert property (sleep_go && idle_select
    |=> in_idle && !cpu_clk_run && periph_cycle_enable)
    else $error("idle not entered");
  a_clk_stop: assert property (in_sleep |-> !cpu_clk_run && !sys_clk_run)
    else $error("clocks run in sleep");
  a_roi_clear: assert property (entry_go && recover_on_irq |=> !slow_run_enable)
    else $error("recover did not clear slow-run");
  a_doe_copy: assert property (entry_go |=> slow_on_return == $past(slow_run_enable))
    else $error("slow-on-return not copied");
  a_return_load: assert property (irq_return && !entry_go && !reset_evt
    |=> slow_run_enable == $past(slow_on_return))
    else $error("return did not restore slow-run");
  a_vector_wait: assert property (q.irq_pend && multicycle_busy |=> !vector_fetch)
    else $error("vector fetched during multicycle");
  a_skip_isr: assert property (entry_go && prefetch_clears_gie
    |=> isr_skipped && !vector_fetch)
    else $error("isr not skipped");
  a_wake_wdt: assert property (wake_go |=> wdt_clear)
    else $error("wake did not clear watchdog");
  a_ost_wait: assert property (s_crystal_wake |=> s_held_off [*8])
    else $error("resumed before oscillator start-up");
  a_periph_run: assert property (q.mode == cpsm_pkg::CPSM_RUN |-> periph_cycle_enable)
    else $error("peripherals throttled");
  a_full_reset: assert property (reset_evt |=> full_reset_req && !in_sleep)
    else $error("reset source did not reset");

endmodule

`default_nettype wire

// *** design/cpsm_pkg.sv ***
// package of constants and types for the cpu power-saving mode controller
// assumes a single 10 MHz system clock that is also the oscillator clock
`default_nettype none

package cpsm_pkg;

  // ==========================================================
  // clock and timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 100;      // system clock period
  localparam int OST_PERIODS = 1024;       // crystal start-up, oscillator periods
  // one oscillator period is one system clock here
  localparam int OST_CYCLES = OST_PERIODS * 100 / CLK_PERIOD_NS;
  localparam int REG_STAB_NS = 10000;      // regulator stabilisation wait
  localparam int REG_STAB_CYCLES = (REG_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 12;               // wake timer width

  // ==========================================================
  // slow-run divider
  // ==========================================================
  localparam int RATIO_W = 3;              // cycle-ratio code width
  localparam int DOZE_CNT_W = 8;           // counter spans up to 1:256
  localparam logic [8:0] DOZE_BASE = 9'h002;  // code 000 gives 1:2
  localparam logic [8:0] DOZE_ONE = 9'h001;

  // ==========================================================
  // core interface sizes and reset values
  // ==========================================================
  localparam int ADDR_W = 15;              // program counter width
  localparam logic [ADDR_W-1:0] IRQ_VECTOR = 15'h0004;  // service entry
  localparam int IO_PORTS = 8;             // i/o ports with a hold latch
  localparam int N_PIN = 3;                // asynchronous reset sources
  localparam int PIN_POWERON = 0;
  localparam int PIN_BROWNOUT = 1;
  localparam int PIN_EXT_RESET = 2;
  localparam logic FLAG_RST = 1'h1;        // status flags after reset
  localparam logic RUN_RST = 1'h1;         // clocks run after reset

  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic [2:0] {
    CPSM_RUN,       // full or throttled execution
    CPSM_IDLE,      // cpu halted, peripherals clocked
    CPSM_SLEEP,     // cpu and system clock stopped
    CPSM_WAKE_OST,  // crystal start-up wait
    CPSM_WAKE_REG,  // regulator stabilisation wait
    CPSM_RESUME     // run the prefetched instruction
  } cpsm_mode_t;

  // software write to the slow-run control bits
  typedef struct packed {
    logic slow_run_enable;
    logic slow_on_return;
  } cpsm_sw_t;

  // one bit per sleep-capable oscillator
  typedef struct packed {
    logic low_freq_internal_osc;
    logic high_freq_internal_osc;
    logic secondary_osc;
  } cpsm_osc_t;

  // slow-run divider state
  typedef struct packed {
    logic [DOZE_CNT_W-1:0] cnt;
    logic cpu_en;
  } cpsm_doze_t;

  // controller state; every top output except cpu_cycle_enable is a field
  typedef struct packed {
    cpsm_mode_t mode;
    logic [N_PIN-1:0] sync1;
    logic [N_PIN-1:0] sync2;
    logic irq_pend;
    logic wake_irq;
    logic [TMR_W-1:0] timer;
    logic [IO_PORTS-1:0] io_latch;
    logic [IO_PORTS-1:0] io_hold;
    cpsm_osc_t osc_run;
    logic [ADDR_W-1:0] vector_addr;
    logic slow_run_enable;
    logic slow_on_return;
    logic powerdown_flag_n;
    logic timeout_flag_n;
    logic wdt_clear;
    logic adc_abort;
    logic adc_powered;
    logic regulator_lowpower;
    logic full_reset_req;
    logic vector_fetch;
    logic isr_skipped;
    logic prefetch_next;
    logic exec_prefetched;
    logic cpu_clk_run;
    logic sys_clk_run;
    logic periph_cycle_enable;
    logic in_idle;
    logic in_sleep;
  } cpsm_state_t;

endpackage

`default_nettype wire

// *** design/cpsm_doze_div.sv ***
// slow-run divider: one cpu cycle enable in every 2^(code+1) cycles
// assumes enable, ratio and run come from logic on the same clock
`default_nettype none

module cpsm_doze_div (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [cpsm_pkg::RATIO_W-1:0] ratio,
  input wire logic run,
  output logic cpu_cycle
);

  // ==========================================================
  // state
  // ==========================================================
  cpsm_pkg::cpsm_doze_t q;       // registered state
  cpsm_pkg::cpsm_doze_t next_q;  // next state
  logic [8:0] span;              // period minus one

  // count the period; pulse when the count wraps
  always_comb begin
    next_q = q;
    span = (cpsm_pkg::DOZE_BASE << ratio) - cpsm_pkg::DOZE_ONE;
    if (!enable) begin
      // full speed: every cycle with run high is a cpu cycle
      next_q.cnt = '0;
      next_q.cpu_en = run;
    end else begin
      // throttled: cnt above span after a ratio change also wraps
      if (q.cnt >= span[cpsm_pkg::DOZE_CNT_W-1:0]) begin
        next_q.cnt = '0;
      end else begin
        next_q.cnt = q.cnt + 1'h1;
      end
      next_q.cpu_en = run && (next_q.cnt == '0);
    end
  end

  // register the state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign cpu_cycle = q.cpu_en;

  // ==========================================================
  // checks
  // ==========================================================
  sequence s_steady_4;
    enable && run && ratio == 3'h1;
  endsequence

  a_doze_ratio_4: assert property (@(posedge clk) disable iff (rst)
    (q.cpu_en && enable && run && ratio == 3'h1) ##1 s_steady_4 [*3] |=> q.cpu_en)
    else $error("slow-run 1:4 pulse not four cycles apart");

  a_doze_gap_32: assert property (@(posedge clk) disable iff (rst)
    (q.cpu_en && enable && ratio == 3'h4) |=> !q.cpu_en)
    else $error("slow-run pulse repeated inside period");

endmodule

`default_nettype wire

// *** sim/cpsm_core_model.sv ***
// core sequencer model: pulses for sleep, interrupt entry and return
// assumes the bench calls its tasks; all changes land at falling edges
`default_nettype none

module cpsm_core_model (
  input wire logic clk,
  output logic sleep_exec,
  output logic irq_entry_req,
  output logic irq_return,
  output logic multicycle_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // idle outputs at time zero
  // ==========================================
  initial begin
    {sleep_exec, irq_entry_req, irq_return, multicycle_busy} = 4'h0;
  end
  // one-cycle sleep instruction
  task automatic do_sleep();
    @(negedge clk) sleep_exec = 1'b1;
    @(negedge clk) sleep_exec = 1'b0;
  endtask
  // entry request; a multicycle instruction may hold the core busy
  task automatic do_entry(input int busy);
    @(negedge clk);
    irq_entry_req = 1'b1;
    multicycle_busy = (busy > 0);
    @(negedge clk) irq_entry_req = 1'b0;
    repeat (busy) @(negedge clk);
    multicycle_busy = 1'b0;
  endtask
  // one-cycle return from interrupt
  task automatic do_return();
    @(negedge clk) irq_return = 1'b1;
    @(negedge clk) irq_return = 1'b0;
  endtask
endmodule

`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the power-saving mode controller
// assumes the package, the controller and the core model are compiled
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OST_P = 9;  // short start-up wait
  localparam int REG_P = 4;  // short regulator wait
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sw_write, recover_on_irq, idle_select, global_irq_enable, adc_rc_clock;
  logic regulator_lowpower_sleep, crystal_osc_mode, prefetch_clears_gie, irq_any;
  logic irq_pending_enabled, wdt_wake, external_reset_pin, brownout_evt, poweron_evt;
  logic sleep_exec, irq_entry_req, irq_return, multicycle_busy;
  cpsm_pkg::cpsm_sw_t sw_data;
  logic [cpsm_pkg::RATIO_W-1:0] cycle_ratio;
  cpsm_pkg::cpsm_osc_t osc_request, osc_force_on, osc_run;
  logic [cpsm_pkg::IO_PORTS-1:0] port_periph_active, io_hold;
  logic cpu_cycle_enable, periph_cycle_enable, cpu_clk_run, sys_clk_run, slow_run_enable;
  logic slow_on_return, powerdown_flag_n, timeout_flag_n, wdt_clear, adc_abort;
  logic adc_powered, regulator_lowpower, full_reset_req, vector_fetch, isr_skipped;
  logic prefetch_next, exec_prefetched, in_idle, in_sleep;
  logic [cpsm_pkg::ADDR_W-1:0] vector_addr;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int cnt, pcnt;
  // rows: ratio code is the index, cpu cycles per 256 beside it
  int exp_cnt [8] = '{128, 64, 32, 16, 8, 4, 2, 1};

  cpsm_ctrl #(.OST_CYCLES(OST_P), .REG_CYCLES(REG_P), .REG_PRESENT(1'b1)) u_cpsm_ctrl (
    .clk, .rst, .sw_write, .sw_data, .cycle_ratio, .recover_on_irq, .idle_select,
    .global_irq_enable, .regulator_lowpower_sleep, .crystal_osc_mode, .adc_rc_clock,
    .sleep_exec, .irq_entry_req, .irq_return, .prefetch_clears_gie, .multicycle_busy,
    .irq_pending_enabled, .irq_any, .wdt_wake, .osc_request, .osc_force_on,
    .port_periph_active, .external_reset_pin, .brownout_evt, .poweron_evt,
    .cpu_cycle_enable, .periph_cycle_enable, .cpu_clk_run, .sys_clk_run,
    .slow_run_enable, .slow_on_return, .powerdown_flag_n, .timeout_flag_n, .wdt_clear,
    .adc_abort, .adc_powered, .osc_run, .io_hold, .regulator_lowpower, .full_reset_req,
    .vector_fetch, .vector_addr, .isr_skipped, .prefetch_next, .exec_prefetched,
    .in_idle, .in_sleep);
  cpsm_core_model u_core (.clk, .sleep_exec, .irq_entry_req, .irq_return,
    .multicycle_busy);

  // ==========================================
  // clock, timeout, helpers
  // ==========================================
  always #50 clk = ~clk;
  // a hang ends the run as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // software write of both slow-run bits
  task automatic sw(input logic s, input logic r);
    @(negedge clk);
    sw_data = {s, r};
    sw_write = 1'b1;
    @(negedge clk) sw_write = 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================
  // main sequence
  // ==========================================
  initial begin
    {sw_write, recover_on_irq, idle_select, regulator_lowpower_sleep} = 4'h0;
    {crystal_osc_mode, adc_rc_clock, prefetch_clears_gie, irq_any} = 4'h0;
    {irq_pending_enabled, wdt_wake, external_reset_pin, brownout_evt, poweron_evt} = 5'h00;
    {global_irq_enable, sw_data, cycle_ratio} = 6'h20;
    {osc_request, osc_force_on, port_periph_active} = {3'h4, 3'h1, 8'h0F};
    tick(3);
    `CHK("rst", 6'h3E, {powerdown_flag_n, timeout_flag_n, osc_run, slow_run_enable})
    rst = 1'b0;
    // throttle ratio table, peripherals counted beside the cpu
    sw(1'b1, 1'b0);
    for (int c = 0; c < 8; c++) begin
      cycle_ratio = c[2:0];
      tick(4);
      {cnt, pcnt} = 64'h0;
      repeat (256) begin
        @(negedge clk);
        cnt += cpu_cycle_enable;
        pcnt += periph_cycle_enable;
      end
      `CHK("cpu_cyc", exp_cnt[c], cnt)
      `CHK("per_cyc", 256, pcnt)
    end
    $display("test ratio done");
    // entry behind a busy multicycle instruction, recover on
    recover_on_irq = 1'b1;
    u_core.do_entry(3);
    `CHK("vec_busy", 1'h0, vector_fetch)
    tick(1);
    `CHK("entry", 18'h30004,
      {vector_fetch, slow_on_return, slow_run_enable, vector_addr})
    u_core.do_return();
    `CHK("ret1", 1'h1, slow_run_enable)
    recover_on_irq = 1'b0;
    u_core.do_entry(0);
    tick(1);
    `CHK("entry2", 3'h7, {vector_fetch, slow_run_enable, slow_on_return})
    sw(1'b1, 1'b0);
    u_core.do_return();
    `CHK("ret0", 1'h0, slow_run_enable)
    // prefetched instruction drops gie: no service, still recovers
    sw(1'b1, 1'b0);
    {recover_on_irq, prefetch_clears_gie} = 2'h3;
    u_core.do_entry(0);
    tick(1);
    `CHK("skip", 3'h4, {isr_skipped, vector_fetch, slow_run_enable})
    {recover_on_irq, prefetch_clears_gie} = 2'h0;
    $display("test entry done");
    // pending enabled interrupt without gie makes sleep a no-op
    {global_irq_enable, irq_pending_enabled} = 2'h1;
    u_core.do_sleep();
    `CHK("nop", 5'h0D,
      {in_sleep, powerdown_flag_n, timeout_flag_n, wdt_clear, prefetch_next})
    {global_irq_enable, irq_pending_enabled} = 2'h2;
    // full sleep and interrupt wake
    u_core.do_sleep();
    `CHK("sleep", 8'h8F, {in_sleep, cpu_clk_run, sys_clk_run, powerdown_flag_n,
      timeout_flag_n, wdt_clear, adc_abort, prefetch_next})
    `CHK("keep", 12'hBE0, {osc_run, io_hold, adc_powered})
    tick(3);
    irq_pending_enabled = 1'b1;
    tick(1);
    irq_pending_enabled = 1'b0;
    `CHK("wake", 2'h1, {in_sleep, wdt_clear})
    tick(1);
    `CHK("exec", 1'h1, exec_prefetched)
    tick(1);
    `CHK("isr", 1'h1, vector_fetch)
    $display("test sleep done");
    // idle and its interrupt exit with gie off
    idle_select = 1'b1;
    u_core.do_sleep();
    `CHK("idle", 4'hA, {in_idle, cpu_clk_run, periph_cycle_enable, in_sleep})
    {global_irq_enable, irq_any} = 2'h1;
    tick(2);
    `CHK("idle_end", 1'h0, in_idle)
    {global_irq_enable, irq_any, idle_select} = 3'h4;
    $display("test idle done");
    // watchdog wake: continues in line, no service call
    u_core.do_sleep();
    wdt_wake = 1'b1;
    tick(1);
    wdt_wake = 1'b0;
    tick(1);
    `CHK("wdt", 3'h2, {full_reset_req, exec_prefetched, vector_fetch})
    tick(1);
    `CHK("wdt_isr", 1'h0, vector_fetch)
    $display("test watchdog wake done");
    // crystal start-up and low-power regulator waits
    {crystal_osc_mode, regulator_lowpower_sleep} = 2'h3;
    u_core.do_sleep();
    `CHK("reg_lp", 1'h1, regulator_lowpower)
    irq_pending_enabled = 1'b1;
    tick(1);
    irq_pending_enabled = 1'b0;
    `CHK("ost", 2'h0, {in_sleep, cpu_clk_run})
    cnt = 1;
    while (exec_prefetched !== 1'b1 && cnt < 100) begin
      tick(1);
      cnt++;
    end
    `CHK("wait", 1'h1, cnt >= OST_P + REG_P && cnt <= OST_P + REG_P + 3)
    {crystal_osc_mode, regulator_lowpower_sleep} = 2'h0;
    $display("test wait done");
    // reset pin: passes the synchroniser, clears slow bits
    sw(1'b1, 1'b1);
    external_reset_pin = 1'b1;
    tick(2);
    `CHK("pin2", 1'h0, full_reset_req)
    tick(1);
    `CHK("pin3", 3'h4, {full_reset_req, slow_run_enable, slow_on_return})
    external_reset_pin = 1'b0;
    tick(4);
    // second reset in mid-run
    rst = 1'b1;
    tick(1);
    `CHK("rst2", 3'h7, {powerdown_flag_n, timeout_flag_n, cpu_clk_run})
    rst = 1'b0;
    tick(2);
    $display("test reset done");
    final_report();
  end
endmodule

`default_nettype wire
